// ===== logic/spoc_regs.svh
// register map, field positions, reset values and timing counts of the sync phase block
`ifndef SPOC_REGS_SVH
`define SPOC_REGS_SVH
`define SPOC_IDX_FRAME_PHASE 8'h7b
`define SPOC_IDX_RAMP_CFG 8'h7c
`define SPOC_RST_FRAME_PHASE 8'h00
`define SPOC_RST_RAMP_CFG 8'h2b
`define SPOC_PHASE_LSB 0
`define SPOC_PHASE_MSB 1
`define SPOC_TRIG_BIT 7
`define SPOC_HALF_UI_CYC 2
`define SPOC_RAMP_STEP_CYC 4
`define SPOC_DIV_RST_CYC 4
`endif

// ===== logic/spoc_pkg.sv
// types shared by the sync phase and offset calibration block
package spoc_pkg;
    typedef enum logic [1:0] {
        SPOC_PH_NOMINAL,
        SPOC_PH_HALF_EARLY,
        SPOC_PH_ONE_LATE,
        SPOC_PH_HALF_LATE
    } spoc_phase_t;
    typedef enum {
        SPOC_IDLE,
        SPOC_HOLD,
        SPOC_RAMP_DN,
        SPOC_DIV_RST,
        SPOC_RAMP_UP,
        SPOC_LEAVE
    } spoc_state_t;
endpackage

// ===== logic/spoc_top.sv
// frame sync sampling phase and phase offset ramp / calibration control with apb registers
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
`include "spoc_regs.svh"

// Notes on behaviour
// - the frame sync input is sampled nominal, half an interval early, one late or half late.
// - with the trigger bit at 0 the applied offset follows the programmed one one step at a time.
// - writing 1 to bit 7 of the ramp configuration register starts a calibration.
// - calibration enters holdover, ramps to zero, resets dividers, ramps back, leaves holdover.
// - calibration runs on its own after the single trigger write.
module spoc_top
    import spoc_pkg::*;
#(
    parameter int OFS_W = 16,
    parameter int HALF_UI_CYC = `SPOC_HALF_UI_CYC,
    parameter int RAMP_STEP_CYC = `SPOC_RAMP_STEP_CYC,
    parameter int DIV_RST_CYC = `SPOC_DIV_RST_CYC
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // external frame sync pin
    input wire logic frame_sync_in,
    output logic frame_sync_sample,
    // phase offset from the offset registers and to the output stage
    input wire logic signed [OFS_W-1:0] prog_offset,
    output logic signed [OFS_W-1:0] out_offset,
    output logic signed [OFS_W-1:0] internal_offset,
    // pll and divider control
    output logic holdover_req,
    output logic div_reset,
    output logic cal_busy
);

    localparam int D_NOM = 2 * HALF_UI_CYC;
    localparam int D_EARLY = HALF_UI_CYC;
    localparam int D_LATE1 = 4 * HALF_UI_CYC;
    localparam int D_LATEH = 3 * HALF_UI_CYC;
    localparam int RST_LAST = DIV_RST_CYC - 1;

    generate
        if (OFS_W < 2 || HALF_UI_CYC < 1 || 4 * HALF_UI_CYC > 255
            || RAMP_STEP_CYC < 1 || RAMP_STEP_CYC > 255
            || DIV_RST_CYC < 1 || DIV_RST_CYC > 255)
        begin : g_bad_params
            $error("spoc_top: parameter out of range");
        end
    endgenerate

    // index on the bus is the word address
    function automatic logic [7:0] word_idx(input logic [11:0] addr);
        return addr[9:2];
    endfunction

    function automatic logic [7:0] phase_delay(input logic [1:0] sel);
        logic [7:0] d;
        d = 8'h00;
        case (spoc_phase_t'(sel))
            SPOC_PH_NOMINAL: d = 8'(D_NOM);
            SPOC_PH_HALF_EARLY: d = 8'(D_EARLY);
            SPOC_PH_ONE_LATE: d = 8'(D_LATE1);
            SPOC_PH_HALF_LATE: d = 8'(D_LATEH);
            default: d = 8'(D_NOM);
        endcase
        return d;
    endfunction

    function automatic logic signed [OFS_W-1:0] step_to(
        input logic signed [OFS_W-1:0] cur,
        input logic signed [OFS_W-1:0] tgt);
        logic signed [OFS_W-1:0] r;
        r = cur;
        if (tgt > cur)
        begin
            r = cur + OFS_W'(1);
        end
        else if (tgt < cur)
        begin
            r = cur - OFS_W'(1);
        end
        return r;
    endfunction

    logic [7:0] phase_cfg_reg;
    logic [7:0] ramp_cfg_reg;
    spoc_state_t state_reg;
    spoc_state_t state_next;
    logic [7:0] step_cnt_reg;
    logic [7:0] rst_cnt_reg;
    logic [7:0] smp_cnt_reg;
    logic sync_ff1_reg;
    logic sync_ff2_reg;
    logic sync_prev_reg;
    logic signed [OFS_W-1:0] frozen_reg;
    logic signed [OFS_W-1:0] ramp_target;
    logic setup_ph;
    logic wr_acc;
    logic addr_ok;
    logic trig_wr;
    logic fall_edge;
    logic step_tick;

    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign addr_ok = word_idx(paddr) == `SPOC_IDX_FRAME_PHASE
        || word_idx(paddr) == `SPOC_IDX_RAMP_CFG;
    assign trig_wr = wr_acc && word_idx(paddr) == `SPOC_IDX_RAMP_CFG
        && pwdata[`SPOC_TRIG_BIT];
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_cfg_reg <= `SPOC_RST_FRAME_PHASE;
        end
        else if (wr_acc && word_idx(paddr) == `SPOC_IDX_FRAME_PHASE)
        begin
            phase_cfg_reg <= pwdata[7:0];
        end
    end

    // the trigger bit doubles as the busy flag, so writing 0 cannot abort a run
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ramp_cfg_reg <= `SPOC_RST_RAMP_CFG;
        end
        else
        begin
            if (wr_acc && word_idx(paddr) == `SPOC_IDX_RAMP_CFG)
            begin
                ramp_cfg_reg[6:0] <= pwdata[6:0];
            end
            ramp_cfg_reg[`SPOC_TRIG_BIT] <= state_next != SPOC_IDLE;
        end
    end

    // read data captured in the setup cycle, held through the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (setup_ph && !pwrite)
        begin
            if (word_idx(paddr) == `SPOC_IDX_FRAME_PHASE)
            begin
                prdata <= {24'h00_0000, phase_cfg_reg};
            end
            else if (word_idx(paddr) == `SPOC_IDX_RAMP_CFG)
            begin
                prdata <= {24'h00_0000, ramp_cfg_reg};
            end
            else
            begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // frame sync pin: two-stage synchroniser, then falling edge detect
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_ff1_reg <= 1'b0;
            sync_ff2_reg <= 1'b0;
            sync_prev_reg <= 1'b0;
        end
        else
        begin
            sync_ff1_reg <= frame_sync_in;
            sync_ff2_reg <= sync_ff1_reg;
            sync_prev_reg <= sync_ff2_reg;
        end
    end

    assign fall_edge = sync_prev_reg && !sync_ff2_reg;

    // one frame in flight; edges during the delay are ignored as frames are far apart
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            smp_cnt_reg <= 8'h00;
            frame_sync_sample <= 1'b0;
        end
        else
        begin
            frame_sync_sample <= smp_cnt_reg == 8'h01;
            if (fall_edge && smp_cnt_reg == 8'h00)
            begin
                smp_cnt_reg <= phase_delay(phase_cfg_reg[`SPOC_PHASE_MSB:`SPOC_PHASE_LSB]);
            end
            else if (smp_cnt_reg != 8'h00)
            begin
                smp_cnt_reg <= smp_cnt_reg - 8'h01;
            end
        end
    end

    // calibration sequencer
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            SPOC_IDLE:
            begin
                if (trig_wr)
                begin
                    state_next = SPOC_HOLD;
                end
            end
            SPOC_HOLD:
            begin
                state_next = SPOC_RAMP_DN;
            end
            SPOC_RAMP_DN:
            begin
                if (internal_offset == '0)
                begin
                    state_next = SPOC_DIV_RST;
                end
            end
            SPOC_DIV_RST:
            begin
                if (rst_cnt_reg == 8'(RST_LAST))
                begin
                    state_next = SPOC_RAMP_UP;
                end
            end
            SPOC_RAMP_UP:
            begin
                if (internal_offset == prog_offset)
                begin
                    state_next = SPOC_LEAVE;
                end
            end
            SPOC_LEAVE:
            begin
                state_next = trig_wr ? SPOC_HOLD : SPOC_IDLE;
            end
            default:
            begin
                state_next = SPOC_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= SPOC_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rst_cnt_reg <= 8'h00;
        end
        else if (state_reg == SPOC_DIV_RST)
        begin
            rst_cnt_reg <= rst_cnt_reg + 8'h01;
        end
        else
        begin
            rst_cnt_reg <= 8'h00;
        end
    end

    // ramp engine shared by normal offset changes and calibration
    assign step_tick = step_cnt_reg == 8'(RAMP_STEP_CYC - 1);
    assign ramp_target = state_reg == SPOC_RAMP_DN ? '0 : prog_offset;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            step_cnt_reg <= 8'h00;
        end
        else
        begin
            step_cnt_reg <= step_tick ? 8'h00 : step_cnt_reg + 8'h01;
        end
    end

    // holding in HOLD, DIV_RST and LEAVE keeps the dividers resetting at a fixed offset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            internal_offset <= '0;
        end
        else if (step_tick && (state_reg == SPOC_IDLE || state_reg == SPOC_RAMP_DN
                 || state_reg == SPOC_RAMP_UP))
        begin
            internal_offset <= step_to(internal_offset, ramp_target);
        end
    end

    // out_offset sees the frozen offset while internal_offset travels
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frozen_reg <= '0;
        end
        else if (state_reg == SPOC_IDLE)
        begin
            frozen_reg <= internal_offset;
        end
    end

    assign out_offset = state_reg == SPOC_IDLE ? internal_offset : frozen_reg;
    assign holdover_req = state_reg != SPOC_IDLE;
    assign div_reset = state_reg == SPOC_DIV_RST;
    assign cal_busy = ramp_cfg_reg[`SPOC_TRIG_BIT];

    sequence s_cal_start;
        state_reg == SPOC_IDLE && trig_wr;
    endsequence

    sequence s_reached_zero;
        state_reg == SPOC_RAMP_DN && internal_offset == '0;
    endsequence

    a_sample_nominal: assert property (@(posedge pclk) disable iff (!presetn)
        fall_edge && smp_cnt_reg == 8'h00 && phase_cfg_reg[1:0] == 2'b00
        |=> ##D_NOM frame_sync_sample)
        else $error("nominal frame sync sample not at the expected cycle");

    a_sample_one_late: assert property (@(posedge pclk) disable iff (!presetn)
        fall_edge && smp_cnt_reg == 8'h00 && phase_cfg_reg[1:0] == 2'b10
        |=> !frame_sync_sample && smp_cnt_reg == 8'(D_LATE1) ##D_LATE1 frame_sync_sample)
        else $error("late frame sync sample mistimed");

    a_ramp_no_step: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == SPOC_IDLE && internal_offset != $past(internal_offset)
        |-> internal_offset - $past(internal_offset) == OFS_W'(1)
            || $past(internal_offset) - internal_offset == OFS_W'(1))
        else $error("applied offset moved by more than one step");

    a_cal_trigger: assert property (@(posedge pclk) disable iff (!presetn)
        s_cal_start |=> state_reg == SPOC_HOLD && cal_busy && holdover_req)
        else $error("trigger write did not start calibration");

    a_cal_order: assert property (@(posedge pclk) disable iff (!presetn)
        s_reached_zero |=> div_reset && rst_cnt_reg == 8'h00
            ##RST_LAST div_reset && rst_cnt_reg == 8'(RST_LAST) ##1 state_reg == SPOC_RAMP_UP)
        else $error("divider reset step out of order");

    a_frozen_output: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg != SPOC_IDLE && $past(state_reg) != SPOC_IDLE |-> $stable(out_offset))
        else $error("visible offset changed during calibration");

    a_autonomous: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == SPOC_HOLD |=> state_reg == SPOC_RAMP_DN && holdover_req)
        else $error("calibration stalled after holdover entry");

    a_trig_clear: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == SPOC_LEAVE && !trig_wr |=> !cal_busy && !holdover_req)
        else $error("trigger bit not cleared at completion");

endmodule // spoc_top

// ===== dv/test_sync_phase_offset_calibration.sv
// self-checking bench for the sync phase and offset calibration block
`timescale 1ns/1ns
`include "spoc_regs.svh"
module test_sync_phase_offset_calibration
    import spoc_pkg::*;
;
    localparam int HU = 2;
    localparam int RS = 4;
    localparam int DR = 4;
    localparam logic [11:0] A_PH = {2'b00, `SPOC_IDX_FRAME_PHASE, 2'b00};
    localparam logic [11:0] A_RC = {2'b00, `SPOC_IDX_RAMP_CFG, 2'b00};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic frame_sync_in = 1'b1;
    logic frame_sync_sample;
    logic signed [15:0] prog_offset = 16'sh0;
    logic signed [15:0] out_offset;
    logic signed [15:0] internal_offset;
    logic holdover_req;
    logic div_reset;
    logic cal_busy;
    int n_errors = 0;
    int checked = 0;

    spoc_top #(.OFS_W(16), .HALF_UI_CYC(HU), .RAMP_STEP_CYC(RS), .DIV_RST_CYC(DR)) u_spoc_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_sync_in(frame_sync_in),
        .frame_sync_sample(frame_sync_sample), .prog_offset(prog_offset),
        .out_offset(out_offset), .internal_offset(internal_offset),
        .holdover_req(holdover_req), .div_reset(div_reset), .cal_busy(cal_busy)
    );

    initial
    begin
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict();
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // holds the request until pready is sampled high, then takes data there
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        forever
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic t_regs();
        logic [31:0] r;
        logic e;
        apb(1'b0, A_PH, 32'h0, r, e);
        chk("phase reg reset", 32'h0, r);
        apb(1'b0, A_RC, 32'h0, r, e);
        chk("ramp cfg reset", 32'h2b, r);
        chk("mapped no error", 32'h0, {31'h0, e});
        chk("ready level", 32'h1, {31'h0, pready});
        apb(1'b1, A_PH, 32'h0000_00fe, r, e);
        apb(1'b0, A_PH, 32'h0, r, e);
        chk("phase reg readback", 32'hfe, r);
        apb(1'b1, 12'h004, 32'h0000_00ff, r, e);
        chk("unmapped write error", 32'h1, {31'h0, e});
        apb(1'b0, 12'h004, 32'h0, r, e);
        chk("unmapped read data", 32'h0, r);
    endtask

    // latency from pin fall to sample pulse, then the pulse must be gone
    task automatic meas(output int n);
        @(posedge pclk);
        frame_sync_in <= 1'b0;
        n = 0;
        while (frame_sync_sample !== 1'b1 && n < 100)
        begin
            @(posedge pclk);
            n++;
        end
        chk("sample pulse seen", 32'h1, {31'h0, frame_sync_sample});
        @(posedge pclk);
        chk("sample pulse width", 32'h0, {31'h0, frame_sync_sample});
        frame_sync_in <= 1'b1;
        repeat (30) @(posedge pclk);
    endtask

    task automatic t_phase();
        int dly [4] = '{2 * HU, HU, 4 * HU, 3 * HU};
        int base;
        int n;
        logic [31:0] r;
        logic e;
        apb(1'b1, A_PH, 32'h0, r, e);
        meas(base);
        for (int c = 1; c < 4; c++)
        begin
            apb(1'b1, A_PH, c, r, e);
            meas(n);
            chk("sample point offset", dly[c] - dly[0], n - base);
        end
    endtask

    task automatic t_ramp(input logic signed [15:0] tgt);
        logic signed [15:0] prev;
        prog_offset <= tgt;
        prev = out_offset;
        repeat (RS * 8 + 10)
        begin
            @(posedge pclk);
            chk("ramp step", 32'h1, {31'h0, (out_offset - prev) inside {-1, 0, 1}});
            prev = out_offset;
        end
        chk("ramp end", {{16{tgt[15]}}, tgt}, {{16{out_offset[15]}}, out_offset});
    endtask

    task automatic t_cal();
        int ndiv = 0;
        int k = 0;
        logic z = 1'b0;
        logic h = 1'b0;
        logic signed [15:0] prev;
        logic [31:0] r;
        logic e;
        apb(1'b1, A_RC, 32'h0000_00ab, r, e);
        prev = internal_offset;
        while (k < 400)
        begin
            @(posedge pclk);
            k++;
            if (holdover_req === 1'b1)
                h = 1'b1;
            if (internal_offset === 16'sh0 && ndiv == 0)
                z = 1'b1;
            if (div_reset === 1'b1)
            begin
                ndiv++;
                chk("divider reset after zero", 32'h1, {31'h0, z});
            end
            chk("frozen output offset", 32'h3, {16'h0, out_offset});
            chk("cal ramp step", 32'h1,
                {31'h0, (internal_offset - prev) inside {-1, 0, 1}});
            prev = internal_offset;
            if (cal_busy === 1'b0 && k > 2)
                break;
        end
        chk("cal finished", 32'h0, {31'h0, cal_busy});
        chk("holdover seen", 32'h1, {31'h0, h});
        chk("divider reset length", DR, ndiv);
        chk("offset restored", 32'h3, {16'h0, internal_offset});
        @(posedge pclk);
        chk("holdover left", 32'h0, {31'h0, holdover_req});
        apb(1'b0, A_RC, 32'h0, r, e);
        chk("trigger cleared", 32'h2b, r);
    endtask

    initial
    begin
        #500000;
        n_errors++;
        print_verdict();
    end

    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_phase();
        t_ramp(16'sh3);
        t_cal();
        t_ramp(-16'sh2);
        t_ramp(16'sh3);
        t_cal();
        print_verdict();
    end
endmodule // test_sync_phase_offset_calibration
